/* File: rtl/osc_auto_cal.sv */
// Oscillator auto calibrator: Wishbone registers, SOF measurement, trim update
`include "osc_cal_map.svh"
`default_nettype none

// Overview of operation
// - Trim select 1 adjusts fine trim, 0 adjusts coarse calibration; 1 recommended.
// - Calibration-on bit enables search for SOF pulse; resets to 0, disabled.
// - Trim register bits 31 to 14 always read zero.
// - Applied oscillator adjustment equals fine trim plus coarse calibration.
// - Fine trim resets to 0x20.
// - One fine trim step is nominally 20 kHz.
// - Coarse calibration resets to 0x80.
// - One coarse step is nominally 40 kHz.
// - Both trim fields are read-only; software writes ignored.
// - Ready flag raises interrupt when its enable is set.
// - Reference-lost flag raises interrupt when its enable is set.
// - Count at or below lower bound (reset 7980) triggers calibration.
// - Count at or above upper bound (reset 0x1f54) triggers; between bounds no change.
module osc_auto_cal
    import osc_cal_pkg::*;
#(
    parameter int unsigned SOF_LOST_CYC = `SOF_LOST_CYC
)(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Reference and oscillator
    input  wire logic        usb_sof,
    input  wire logic        osc_clk_tick,
    // Oscillator trim and interrupt
    output logic      [8:0]  osc_adjust,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] sof_sync_r;
    logic [1:0] tick_sync_r;
    logic       sof_prev_r;
    logic       tick_prev_r;
    logic       sof_pulse;
    logic       tick_pulse;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sof_sync_r  <= 2'h0;
            tick_sync_r <= 2'h0;
            sof_prev_r  <= 1'b0;
            tick_prev_r <= 1'b0;
        end else begin
            sof_sync_r  <= {sof_sync_r[0], usb_sof};
            tick_sync_r <= {tick_sync_r[0], osc_clk_tick};
            sof_prev_r  <= sof_sync_r[1];
            tick_prev_r <= tick_sync_r[1];
        end
    end

    assign sof_pulse  = sof_sync_r[1] & ~sof_prev_r;
    assign tick_pulse = tick_sync_r[1] & ~tick_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode
    wb_req_t    req;
    logic       bus_hit;
    logic       wr_en;
    logic       calibration_on_r;
    logic       trim_field_select_r;
    logic [15:0] lower_trigger_bound_r;
    logic [15:0] target_count_r;
    logic [15:0] upper_trigger_bound_r;
    logic [1:0] status_r;
    logic [1:0] int_enable_r;
    trim_pair_t trim_r;
    trim_pair_t trim_nxt;

    assign req     = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    assign bus_hit = req.cyc & req.stb & ~wb_ack_o;
    assign wr_en   = bus_hit & req.we;

    always_ff @(posedge sys_clk) begin
        if (srst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_hit;
    end

    // Only low byte lanes matter; 16-bit bounds need lanes 0 and 1
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            calibration_on_r      <= 1'b0;
            trim_field_select_r   <= 1'b0;
            lower_trigger_bound_r <= `LOWER_BOUND_RST;
            target_count_r        <= `TARGET_RST;
            upper_trigger_bound_r <= `UPPER_BOUND_RST;
            int_enable_r          <= 2'h0;
        end else if (wr_en) begin
            unique case ({req.adr[4:2], 2'b00})
                `CTRL1_OFS: if (req.sel[0]) begin
                    calibration_on_r    <= req.dat[`CALIBRATION_ON_BIT];
                    trim_field_select_r <= req.dat[`TRIM_FIELD_SELECT_BIT];
                end
                `LOWER_BOUND_OFS: begin
                    if (req.sel[0]) lower_trigger_bound_r[7:0]  <= req.dat[7:0];
                    if (req.sel[1]) lower_trigger_bound_r[15:8] <= req.dat[15:8];
                end
                `TARGET_OFS: begin
                    if (req.sel[0]) target_count_r[7:0]  <= req.dat[7:0];
                    if (req.sel[1]) target_count_r[15:8] <= req.dat[15:8];
                end
                `UPPER_BOUND_OFS: begin
                    if (req.sel[0]) upper_trigger_bound_r[7:0]  <= req.dat[7:0];
                    if (req.sel[1]) upper_trigger_bound_r[15:8] <= req.dat[15:8];
                end
                `INT_ENABLE_OFS: if (req.sel[0]) int_enable_r <= req.dat[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_hit && !req.we) begin
            unique case ({req.adr[4:2], 2'b00})
                `CTRL1_OFS:       wb_dat_o <= {30'h0, trim_field_select_r, calibration_on_r};
                `TRIM_VALUES_OFS: wb_dat_o <= {18'h00000, trim_r};
                `LOWER_BOUND_OFS: wb_dat_o <= {16'h0000, lower_trigger_bound_r};
                `TARGET_OFS:      wb_dat_o <= {16'h0000, target_count_r};
                `UPPER_BOUND_OFS: wb_dat_o <= {16'h0000, upper_trigger_bound_r};
                `STATUS_OFS:      wb_dat_o <= {30'h0, status_r};
                `INT_ENABLE_OFS:  wb_dat_o <= {30'h0, int_enable_r};
                default:          wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement between SOF pulses
    cal_state_t  state_r;
    logic [15:0] osc_count_r;
    logic [31:0] sof_wait_r;
    logic        decide_r;
    logic        go_up_r;
    logic        go_down_r;
    logic        ready_evt_r;
    logic        lost_evt_r;
    logic        lost;

    assign lost = (sof_wait_r >= SOF_LOST_CYC - 1);

    // Needs SOF every 1 ms; the lost timer flags a missing host
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r     <= ST_IDLE;
            osc_count_r <= 16'h0000;
            sof_wait_r  <= 32'h0;
            decide_r    <= 1'b0;
            go_up_r     <= 1'b0;
            go_down_r   <= 1'b0;
            ready_evt_r <= 1'b0;
            lost_evt_r  <= 1'b0;
        end else begin
            decide_r    <= 1'b0;
            ready_evt_r <= 1'b0;
            lost_evt_r  <= 1'b0;
            if (!calibration_on_r) begin
                state_r    <= ST_IDLE;
                sof_wait_r <= 32'h0;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        state_r    <= ST_SEARCH;
                        sof_wait_r <= 32'h0;
                    end
                    ST_SEARCH: begin
                        if (sof_pulse) begin
                            state_r     <= ST_MEASURE;
                            osc_count_r <= 16'h0000;
                            sof_wait_r  <= 32'h0;
                        end
                    end
                    ST_MEASURE: begin
                        if (sof_pulse) begin
                            osc_count_r <= 16'h0000;
                            sof_wait_r  <= 32'h0;
                            decide_r    <= 1'b1;
                            // Clock low -> step up, clock high -> step down
                            go_up_r     <= (osc_count_r <= lower_trigger_bound_r);
                            go_down_r   <= (osc_count_r >= upper_trigger_bound_r);
                            ready_evt_r <= (osc_count_r > lower_trigger_bound_r) &&
                                           (osc_count_r < upper_trigger_bound_r);
                        end else if (lost) begin
                            state_r    <= ST_SEARCH;
                            lost_evt_r <= 1'b1;
                            sof_wait_r <= 32'h0;
                        end else begin
                            sof_wait_r <= sof_wait_r + 32'h1;
                            if (tick_pulse && osc_count_r != 16'hffff)
                                osc_count_r <= osc_count_r + 16'h0001;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trim update
    osc_cal_step u_step (
        .cur         (trim_r),
        .select_fine (trim_field_select_r),
        .go_up       (go_up_r),
        .go_down     (go_down_r),
        .nxt         (trim_nxt)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trim_r.fine_trim_value  <= `FINE_TRIM_RST;
            trim_r.coarse_cal_value <= `COARSE_CAL_RST;
        end else if (decide_r && calibration_on_r) begin
            trim_r <= trim_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            osc_adjust <= 9'(`FINE_TRIM_RST) + 9'(`COARSE_CAL_RST);
        else
            osc_adjust <= 9'(trim_r.fine_trim_value) + 9'(trim_r.coarse_cal_value);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status, clear register, interrupt
    logic [1:0] clr_mask;
    assign clr_mask = (wr_en && req.sel[0] && {req.adr[4:2], 2'b00} == `INT_CLEAR_OFS) ? req.dat[1:0] : 2'h0;

    // Set wins over a simultaneous clear
    always_ff @(posedge sys_clk) begin
        if (srst)
            status_r <= 2'h0;
        else
            status_r <= (status_r & ~clr_mask) | {lost_evt_r, ready_evt_r};
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(status_r & int_enable_r);
    end

endmodule // osc_auto_cal
`default_nettype wire

/* File: rtl/osc_cal_map.svh */
// Register offsets, field positions, reset values and timing counts of the calibrator
`ifndef OSC_CAL_MAP_SVH
`define OSC_CAL_MAP_SVH

// Five bits wide to match the byte address of the bus
`define CTRL1_OFS           5'h00
`define TRIM_VALUES_OFS     5'h04
`define LOWER_BOUND_OFS     5'h08
`define TARGET_OFS          5'h0c
`define UPPER_BOUND_OFS     5'h10
`define STATUS_OFS          5'h14
`define INT_ENABLE_OFS      5'h18
`define INT_CLEAR_OFS       5'h1c

`define CALIBRATION_ON_BIT           0
`define TRIM_FIELD_SELECT_BIT          1
`define STS_READY_BIT       0
`define STS_LOST_BIT        1

`define FINE_TRIM_RST       6'h20
`define COARSE_CAL_RST      8'h80
`define LOWER_BOUND_RST     16'h1f2c
`define TARGET_RST          16'h1f40
`define UPPER_BOUND_RST     16'h1f54

`define FINE_STEP_KHZ       20
`define COARSE_STEP_KHZ     40
`define CLK_MHZ             50
`define SOF_PERIOD_US       1000
`define SOF_LOST_US         1100
`define SOF_LOST_CYC        ((`SOF_LOST_US * `CLK_MHZ))

`endif

/* File: rtl/osc_cal_pkg.sv */
// Types shared by the oscillator calibrator
`default_nettype none
package osc_cal_pkg;
    typedef struct packed {
        logic [5:0] fine_trim_value;
        logic [7:0] coarse_cal_value;
    } trim_pair_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [4:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SEARCH  = 2'b01,
        ST_MEASURE = 2'b10
    } cal_state_t;
endpackage
`default_nettype wire

/* File: rtl/osc_cal_step.sv */
// Saturating one-step update of the selected trim field
`default_nettype none
module osc_cal_step
    import osc_cal_pkg::*;
(
    // Decision inputs
    input  wire trim_pair_t cur,
    input  wire logic       select_fine,
    input  wire logic       go_up,
    input  wire logic       go_down,
    // Updated pair
    output var  trim_pair_t nxt
);
    always_comb begin
        nxt = cur;
        if (select_fine) begin
            if (go_up && cur.fine_trim_value != 6'h3f)
                nxt.fine_trim_value = cur.fine_trim_value + 6'h01;
            else if (go_down && cur.fine_trim_value != 6'h00)
                nxt.fine_trim_value = cur.fine_trim_value - 6'h01;
        end else begin
            if (go_up && cur.coarse_cal_value != 8'hff)
                nxt.coarse_cal_value = cur.coarse_cal_value + 8'h01;
            else if (go_down && cur.coarse_cal_value != 8'h00)
                nxt.coarse_cal_value = cur.coarse_cal_value - 8'h01;
        end
    end
endmodule // osc_cal_step
`default_nettype wire

/* File: tb/sof_osc_model.sv */
// Model of the USB start-of-frame source and the oscillator tick output
`default_nettype none
module sof_osc_model #(
    parameter int SOF_CYC = 100
)(
    // Clock
    input  wire logic       sys_clk,
    // Controls from the bench
    input  wire logic       sof_en,
    input  wire logic [7:0] tick_div,
    // Reference and oscillator
    output var  logic       usb_sof,
    output var  logic       osc_clk_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    int sof_cnt = 0;
    int tick_cnt = 0;
    // Frame pulse stays low while the reference is withdrawn
    always @(posedge sys_clk) begin
        sof_cnt <= (sof_cnt == SOF_CYC - 1) ? 0 : sof_cnt + 1;
        usb_sof <= sof_en && sof_cnt < 2;
    end
    // One-cycle tick keeps the rate at or below half the system clock for tick_div of 2 or more
    always @(posedge sys_clk) begin
        tick_cnt <= (tick_cnt >= int'(tick_div) - 1) ? 0 : tick_cnt + 1;
        osc_clk_tick <= tick_cnt == 0;
    end
endmodule // sof_osc_model
`default_nettype wire

/* File: tb/osc_auto_cal_checker.sv */
// Assertions on the calibrator's bus and trim outputs
`default_nettype none
module osc_auto_cal_checker #(
    parameter int unsigned SOF_LOST_CYC = 55000
)(
    input wire logic        sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic        wb_ack_o, usb_sof, osc_clk_tick, irq,
    input wire logic [8:0]  osc_adjust
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic       cal_on_r;
    logic [3:0] off_cnt_r;
    logic [3:0] sof_age_r;
    logic [1:0] sof_d_r;
    always_ff @(posedge sys_clk) begin
        if (srst) cal_on_r <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 5'h0 && wb_sel_i[0])
            cal_on_r <= wb_dat_i[0];
    end
    // Margin for a measurement already in flight when software turns off
    always_ff @(posedge sys_clk) begin
        if (srst || cal_on_r) off_cnt_r <= 4'h0;
        else if (off_cnt_r != 4'hf) off_cnt_r <= off_cnt_r + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        sof_d_r <= {sof_d_r[0], usb_sof};
        if (sof_d_r[0] && !sof_d_r[1]) sof_age_r <= 4'h0;
        else if (sof_age_r != 4'hf) sof_age_r <= sof_age_r + 4'h1;
    end
    property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_upper_zero; (wb_ack_o && !wb_we_i && wb_adr_i == 5'h04) |-> wb_dat_o[31:14] == 18'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("trim upper bits not zero");
    property p_sum;
        (wb_ack_o && !wb_we_i && wb_adr_i == 5'h04 && $stable(osc_adjust))
            |-> osc_adjust == {3'h0, wb_dat_o[13:8]} + {1'b0, wb_dat_o[7:0]};
    endproperty
    a_sum: assert property (p_sum) else $error("adjust not fine plus coarse");
    property p_reset_val; $fell(srst) |-> osc_adjust == 9'h0a0; endproperty
    a_reset_val: assert property (p_reset_val) else $error("adjust reset value wrong");
    property p_off_hold; off_cnt_r == 4'hf |-> $stable(osc_adjust); endproperty
    a_off_hold: assert property (p_off_hold) else $error("adjust moved while off");
    property p_step;
        $changed(osc_adjust) |-> (osc_adjust == $past(osc_adjust) + 9'h1 || osc_adjust == $past(osc_adjust) - 9'h1);
    endproperty
    a_step: assert property (p_step) else $error("adjust moved more than one step");
    property p_sof_cause; $changed(osc_adjust) |-> sof_age_r <= 4'hc; endproperty
    a_sof_cause: assert property (p_sof_cause) else $error("adjust moved without frame pulse");
endmodule // osc_auto_cal_checker
bind osc_auto_cal osc_auto_cal_checker #(.SOF_LOST_CYC(SOF_LOST_CYC)) chk (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .usb_sof(usb_sof), .osc_clk_tick(osc_clk_tick), .irq(irq), .osc_adjust(osc_adjust));
`default_nettype wire

/* File: tb/osc_auto_cal_bench.sv */
// Self-checking bench for the oscillator auto calibrator
`default_nettype none
module osc_auto_cal_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sof_en = 1'b1;
    logic [3:0]  sel = 4'h0;
    logic [4:0]  adr = 5'h0;
    logic [31:0] dat = 32'h0, dat_o, q, q1;
    logic [7:0]  tick_div = 8'h05;
    logic        ack, sof, tick, irq;
    logic [8:0]  adj;
    int          err_count = 0, cmp_count = 0, clk_cnt = 0;
    osc_auto_cal #(.SOF_LOST_CYC(200)) dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .usb_sof(sof), .osc_clk_tick(tick), .osc_adjust(adj), .irq(irq));
    sof_osc_model far (.sys_clk(sys_clk), .sof_en(sof_en), .tick_div(tick_div), .usb_sof(sof),
        .osc_clk_tick(tick));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic stop_test;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data is taken at the edge that samples ack high
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        clk_cnt++;
        if (clk_cnt == 20000) begin
            err_count++;
            $display("[FAIL] %0t run did not finish", $time);
            stop_test();
        end
    end
    initial begin
        wt(3);
        srst <= 1'b0;
        wb(5'h04, 1'b0, 32'h0);
        check(q, 32'h2080);
        check(adj, 32'h0a0);
        wb(5'h00, 1'b0, 32'h0);
        check(q, 32'h0);
        check(irq, 32'h0);
        wb(5'h04, 1'b1, 32'hffffffff);
        wb(5'h04, 1'b0, 32'h0);
        check(q, 32'h2080);
        wb(5'h1c, 1'b0, 32'h0);
        check(q, 32'h0);
        // Small bounds: ticks every 5/10/20 cycles give 20/10/5 per frame
        wb(5'h08, 1'b1, 32'h8);
        wb(5'h10, 1'b1, 32'hc);
        wb(5'h18, 1'b1, 32'h3);
        wb(5'h00, 1'b1, 32'h3);
        wt(700);
        wb(5'h04, 1'b0, 32'h0);
        check(q[13:8] < 6'h20, 32'h1);
        check(q[7:0], 32'h80);
        check(adj, {23'h0, 3'h0, q[13:8]} + {24'h0, q[7:0]});
        wb(5'h00, 1'b1, 32'h2);
        wb(5'h04, 1'b0, 32'h0);
        q1 = q;
        wt(500);
        wb(5'h04, 1'b0, 32'h0);
        check(q, q1);
        tick_div <= 8'h14;
        wb(5'h00, 1'b1, 32'h1);
        wt(700);
        wb(5'h04, 1'b0, 32'h0);
        check(q[13:8], q1[13:8]);
        check(q[7:0] > 8'h80, 32'h1);
        tick_div <= 8'h0a;
        wt(500);
        wb(5'h14, 1'b0, 32'h0);
        check(q[0], 32'h1);
        check(irq, 32'h1);
        wb(5'h00, 1'b1, 32'h0);
        wb(5'h18, 1'b1, 32'h0);
        wt(3);
        check(irq, 32'h0);
        wb(5'h1c, 1'b1, 32'h3);
        wb(5'h14, 1'b0, 32'h0);
        check(q, 32'h0);
        // Reference withdrawn mid-measurement
        wb(5'h18, 1'b1, 32'h2);
        wb(5'h00, 1'b1, 32'h1);
        wt(150);
        sof_en <= 1'b0;
        wt(400);
        wb(5'h14, 1'b0, 32'h0);
        check(q[1], 32'h1);
        check(irq, 32'h1);
        stop_test();
    end
endmodule // osc_auto_cal_bench
`default_nettype wire
